// [i2c_port_pkg.sv]
package i2c_port_pkg;

    // ------------------------------------------------------------
    // target addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_FIXED = 7'h28; // single-address version
    localparam logic [6:0] ADDR_SEL0 = 7'h68; // factory select low
    localparam logic [6:0] ADDR_SEL1 = 7'h6c; // factory select high

    // ------------------------------------------------------------
    // register map seen through the port
    // ------------------------------------------------------------
    localparam logic [7:0] REG_LOW_FIRST = 8'h00; // first of the low block
    localparam logic [7:0] REG_LOW_LAST = 8'h07; // last of the low block
    localparam logic [7:0] REG_LOCK_MASK = 8'h50; // lock mask register
    localparam logic [7:0] REG_LOCK_KEY = 8'h51; // lock password register
    localparam logic [7:0] REG_NO_INC = 8'h00; // pointer holds while writing here
    localparam logic [7:0] PTR_STEP = 8'h01; // pointer increment
    localparam logic [7:0] PTR_RESET = 8'h00; // pointer after reset

    // ------------------------------------------------------------
    // bit counting
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8; // data bits in a byte
    localparam logic [3:0] ACK_SEEN = 4'h1; // ninth pulse sampled
    localparam logic [3:0] CNT_RESET = 4'h0; // bit counter cleared

    // protocol position
    typedef enum logic [3:0] {
        IDLE,
        ADDR,
        ADDR_ACK,
        REG,
        REG_ACK,
        WDATA,
        WDATA_ACK,
        RDATA,
        RACK,
        WAIT_STOP
    } port_state_t;

    // write strobe towards the register file
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    // state held on the link clock
    typedef struct packed {
        logic smp; // data level at the last rising clock
        logic tgl; // flips once per rising clock
    } link_regs_t;

    // state held on the system clock
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic tg_m;
        logic tg_s;
        logic tg_d;
        logic sel_m;
        logic sel_s;
        logic [1:0] strap_dly;
        logic strap_done;
        logic [6:0] own;
        port_state_t state;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic rw;
        logic hack;
        logic drv;
        reg_wr_t wr;
    } port_regs_t;

    // register addresses that the port acknowledges
    function automatic logic reg_valid(input logic [7:0] a);
        reg_valid = (a >= REG_LOW_FIRST && a <= REG_LOW_LAST) || a == REG_LOCK_MASK || a == REG_LOCK_KEY;
    endfunction

endpackage

// [i2c_register_access_slave.sv]
`timescale 1ns/1ps
// What this block does
// - idle bus: both lines released high
// - data change during clock high is start/stop
// - start, 7-bit address, write; ack own address
// - ack valid register address, nack invalid one
// - single write: one byte acked and stored
// - pointer advances per written byte, except 0x00
// - burst write repeats byte plus ack
// - repeated start, read address acked, then data
// - single read: one byte out, host nacks
// - burst read: host acks all but last
// - ack: data low across ninth pulse
// - nack: data released across ninth pulse
// - sample on rising clock; data steady while high
// - own address fixed or factory selected
module i2c_register_access_slave #(
    parameter int FIXED_ADDR_VERSION = 0 // 1: single fixed address, 0: factory selected
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic factory_address_select_i,
    output i2c_port_pkg::reg_wr_t wr_o,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (FIXED_ADDR_VERSION < 0 || FIXED_ADDR_VERSION > 1) begin : g_bad_version
        $error("FIXED_ADDR_VERSION must be 0 or 1");
    end

    // ------------------------------------------------------------
    // link clock side
    // ------------------------------------------------------------
    i2c_port_pkg::link_regs_t link; // held on scl
    i2c_port_pkg::link_regs_t next_link; // next link state

    // sample data on each rising scl, flag it by a toggle
    always_comb begin
        next_link = link;
        next_link.smp = sda_i;
        next_link.tgl = ~link.tgl;
    end

    // the bus clock stops between frames; only bit capture lives here
    always_ff @(posedge scl_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // ------------------------------------------------------------
    // system clock side
    // ------------------------------------------------------------
    i2c_port_pkg::port_regs_t st; // all system-side state
    i2c_port_pkg::port_regs_t next_st; // next system-side state

    logic fall_ev; // scl fell
    logic sample_ev; // a new bit arrived from the link side
    logic start_ev; // data fell while clock high
    logic stop_ev; // data rose while clock high
    logic addr_hit; // received address is ours

    // events seen only on the settled copies, never the first stage
    assign fall_ev = st.scl_d & ~st.scl_s;
    assign sample_ev = st.tg_s ^ st.tg_d;
    assign start_ev = st.scl_s & st.scl_d & st.sda_d & ~st.sda_s;
    assign stop_ev = st.scl_s & st.scl_d & ~st.sda_d & st.sda_s;
    assign addr_hit = st.shreg[7:1] == st.own && st.strap_done;

    // protocol engine
    always_comb begin
        next_st = st;
        // two-stage synchronisers
        next_st.scl_m = scl_i;
        next_st.scl_s = st.scl_m;
        next_st.scl_d = st.scl_s;
        next_st.sda_m = sda_i;
        next_st.sda_s = st.sda_m;
        next_st.sda_d = st.sda_s;
        next_st.tg_m = link.tgl; // smp stays put until the next rising scl
        next_st.tg_s = st.tg_m;
        next_st.tg_d = st.tg_s;
        next_st.sel_m = factory_address_select_i;
        next_st.sel_s = st.sel_m;
        next_st.wr.en = 1'b0;
        // strap taken once, after it has passed both stages
        next_st.strap_dly = {st.strap_dly[0], 1'b1};
        if (!st.strap_done && st.strap_dly == 2'b11) begin
            next_st.strap_done = 1'b1;
            if (FIXED_ADDR_VERSION == 1) begin
                next_st.own = i2c_port_pkg::ADDR_FIXED;
            end else begin
                next_st.own = st.sel_s ? i2c_port_pkg::ADDR_SEL1 : i2c_port_pkg::ADDR_SEL0;
            end
        end
        if (stop_ev) begin
            // stop ends everything and frees the line
            next_st.state = i2c_port_pkg::IDLE;
            next_st.drv = 1'b0;
        end else if (start_ev) begin
            // start or repeated start restarts address reception
            next_st.state = i2c_port_pkg::ADDR;
            next_st.cnt = i2c_port_pkg::CNT_RESET;
            next_st.drv = 1'b0;
        end else begin
            case (st.state)
                i2c_port_pkg::ADDR, i2c_port_pkg::REG, i2c_port_pkg::WDATA: begin
                    // receive shift, msb first
                    if (sample_ev) begin
                        next_st.shreg = {st.shreg[6:0], link.smp};
                        next_st.cnt = st.cnt + 4'h1;
                    end
                    if (fall_ev && st.cnt == i2c_port_pkg::BITS_PER_BYTE) begin
                        next_st.cnt = i2c_port_pkg::CNT_RESET;
                        if (st.state == i2c_port_pkg::ADDR) begin
                            // foreign address: stay off the bus
                            if (addr_hit) begin
                                next_st.drv = 1'b1;
                                next_st.rw = st.shreg[0];
                                next_st.state = i2c_port_pkg::ADDR_ACK;
                            end else begin
                                next_st.state = i2c_port_pkg::IDLE;
                            end
                        end else if (st.state == i2c_port_pkg::REG) begin
                            if (i2c_port_pkg::reg_valid(st.shreg)) begin
                                next_st.drv = 1'b1;
                                next_st.ptr = st.shreg;
                                next_st.state = i2c_port_pkg::REG_ACK;
                            end else begin
                                next_st.state = i2c_port_pkg::WAIT_STOP;
                            end
                        end else begin
                            // data byte: ack, store if the pointer is valid, repeated for bursts
                            next_st.drv = 1'b1;
                            next_st.wr.en = i2c_port_pkg::reg_valid(st.ptr);
                            next_st.wr.addr = st.ptr;
                            next_st.wr.data = st.shreg;
                            if (st.ptr != i2c_port_pkg::REG_NO_INC) begin
                                next_st.ptr = st.ptr + i2c_port_pkg::PTR_STEP;
                            end
                            next_st.state = i2c_port_pkg::WDATA_ACK;
                        end
                    end
                end
                i2c_port_pkg::ADDR_ACK, i2c_port_pkg::REG_ACK, i2c_port_pkg::WDATA_ACK: begin
                    // hold the line low through the ninth pulse
                    if (sample_ev) begin
                        next_st.cnt = i2c_port_pkg::ACK_SEEN;
                    end
                    if (fall_ev && st.cnt == i2c_port_pkg::ACK_SEEN) begin
                        next_st.cnt = i2c_port_pkg::CNT_RESET;
                        next_st.drv = 1'b0;
                        if (st.state == i2c_port_pkg::ADDR_ACK && st.rw) begin
                            next_st.tx = rd_data_i;
                            next_st.drv = ~rd_data_i[7];
                            next_st.state = i2c_port_pkg::RDATA;
                        end else if (st.state == i2c_port_pkg::ADDR_ACK) begin
                            next_st.state = i2c_port_pkg::REG;
                        end else begin
                            next_st.state = i2c_port_pkg::WDATA;
                        end
                    end
                end
                i2c_port_pkg::RDATA: begin
                    // shift out on falling scl so data is steady while high
                    if (sample_ev) begin
                        next_st.cnt = st.cnt + 4'h1;
                    end
                    if (fall_ev) begin
                        if (st.cnt == i2c_port_pkg::BITS_PER_BYTE) begin
                            next_st.cnt = i2c_port_pkg::CNT_RESET;
                            next_st.drv = 1'b0;
                            next_st.ptr = st.ptr + i2c_port_pkg::PTR_STEP;
                            next_st.state = i2c_port_pkg::RACK;
                        end else begin
                            next_st.tx = {st.tx[6:0], 1'b0};
                            next_st.drv = ~st.tx[6];
                        end
                    end
                end
                i2c_port_pkg::RACK: begin
                    // host answer decides whether another byte follows
                    if (sample_ev) begin
                        next_st.hack = ~link.smp;
                        next_st.cnt = i2c_port_pkg::ACK_SEEN;
                    end
                    if (fall_ev && st.cnt == i2c_port_pkg::ACK_SEEN) begin
                        next_st.cnt = i2c_port_pkg::CNT_RESET;
                        if (st.hack) begin
                            next_st.tx = rd_data_i;
                            next_st.drv = ~rd_data_i[7];
                            next_st.state = i2c_port_pkg::RDATA;
                        end else begin
                            next_st.state = i2c_port_pkg::WAIT_STOP;
                        end
                    end
                end
                default: begin
                    // idle or waiting for stop: line released
                    next_st.drv = 1'b0;
                end
            endcase
        end
    end

    // one register bank for the whole engine
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
            st.scl_m <= 1'b1; // an idle bus reads high
            st.scl_s <= 1'b1;
            st.scl_d <= 1'b1;
            st.sda_m <= 1'b1;
            st.sda_s <= 1'b1;
            st.sda_d <= 1'b1;
            st.state <= i2c_port_pkg::IDLE;
            st.ptr <= i2c_port_pkg::PTR_RESET;
        end else begin
            st <= next_st;
        end
    end

    // open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = st.drv;
    assign wr_o = st.wr;
    assign rd_addr_o = st.ptr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence last_bit_fall_s;
        fall_ev && st.cnt == i2c_port_pkg::BITS_PER_BYTE && !start_ev && !stop_ev;
    endsequence

    sequence ack_pulse_s;
        sample_ev ##1 sda_oe_o;
    endsequence

    idle_line_free_a: assert property (st.state == i2c_port_pkg::IDLE |-> !sda_oe_o)
        else $error("line driven while idle");
    start_restarts_a: assert property (start_ev && !stop_ev |=> st.state == i2c_port_pkg::ADDR && st.cnt == 4'h0)
        else $error("start not taken");
    stop_frees_a: assert property (stop_ev |=> st.state == i2c_port_pkg::IDLE ##1 !sda_oe_o)
        else $error("stop not taken");
    addr_ack_a: assert property ((st.state == i2c_port_pkg::ADDR && addr_hit) and last_bit_fall_s
        |=> st.state == i2c_port_pkg::ADDR_ACK && sda_oe_o)
        else $error("own address not acked");
    reg_nack_a: assert property ((st.state == i2c_port_pkg::REG
        && !i2c_port_pkg::reg_valid(st.shreg)) and last_bit_fall_s
        |=> !sda_oe_o && st.state == i2c_port_pkg::WAIT_STOP)
        else $error("bad register address acked");
    write_store_a: assert property ((st.state == i2c_port_pkg::WDATA
        && i2c_port_pkg::reg_valid(st.ptr)) and last_bit_fall_s
        |=> wr_o.en && wr_o.data == $past(st.shreg) && wr_o.addr == $past(st.ptr))
        else $error("data byte not stored");
    ptr_step_a: assert property (st.state == i2c_port_pkg::WDATA and last_bit_fall_s
        |=> st.ptr == ($past(st.ptr) == 8'h00 ? 8'h00 : $past(st.ptr) + 8'h01))
        else $error("write pointer wrong");
    read_ptr_a: assert property (st.state == i2c_port_pkg::RDATA and last_bit_fall_s
        |=> st.ptr == $past(st.ptr) + 8'h01 && !sda_oe_o)
        else $error("read pointer or release wrong");
    host_nack_a: assert property (st.state == i2c_port_pkg::RACK && fall_ev && st.cnt == 4'h1 && !st.hack
        && !start_ev && !stop_ev |=> st.state == i2c_port_pkg::WAIT_STOP ##1 !sda_oe_o)
        else $error("still driving after host nack");
    ack_hold_a: assert property (st.state == i2c_port_pkg::WDATA_ACK && sda_oe_o && !start_ev && !stop_ev
        |-> ack_pulse_s or !sample_ev)
        else $error("ack dropped during ninth pulse");
    read_steady_a: assert property (st.state == i2c_port_pkg::RDATA && !fall_ev && !start_ev && !stop_ev
        |=> $stable(sda_oe_o))
        else $error("data changed outside clock low");

endmodule

// [i2c_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// host controller: makes the bus clock, pulls data low
// ------------------------------------------------------------
module i2c_host_model (
    output logic scl_o,
    output logic pull_o,
    input wire logic sda_i
);
    localparam time HALF = 750; // half bus period, about 667 kHz
    // both lines released, clock stands still between frames
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    // start or repeated start: data falls while clock high
    task automatic start();
        #(HALF / 2) pull_o = 1'b0;
        #(HALF / 2) scl_o = 1'b1;
        #HALF pull_o = 1'b1;
        #HALF scl_o = 1'b0;
    endtask
    // stop: data rises while clock high, bus then idle
    task automatic stop();
        #(HALF / 2) pull_o = 1'b1;
        #(HALF / 2) scl_o = 1'b1;
        #HALF pull_o = 1'b0;
        #HALF;
    endtask
    // one bit: data only moves mid-low, sampled mid-high
    task automatic bit_x(input logic b, output logic s);
        #(HALF / 2) pull_o = ~b;
        #(HALF / 2) scl_o = 1'b1;
        #(HALF / 2) s = sda_i;
        #(HALF / 2) scl_o = 1'b0;
    endtask
    // byte out msb first, ninth pulse released for the answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        int i;
        for (i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    // byte in, then ack or nack on the ninth pulse
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        int i;
        for (i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
        bit_x(~ack, s);
    endtask
endmodule

// [i2c_register_access_slave_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module i2c_register_access_slave_tb;
    // ------------------------------------------------------------
    // signals and models
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic strap = 1'b0; // factory select strap
    logic scl, host_pull, sda_oe, sda_o;
    logic sda_oe_fixed; // pull from the fixed-address port
    wire logic sda; // wired-and bus with pull-up
    i2c_port_pkg::reg_wr_t wr;
    logic [7:0] rd_addr;
    logic [7:0] rf [0:255]; // register file behind the port
    logic [7:0] mdl [0:255]; // expected register contents
    logic [15:0] wq [$]; // strobes seen
    logic [15:0] eq [$]; // strobes expected
    logic [6:0] own = 7'h68; // address the bench talks to
    logic [7:0] ptr; // model pointer
    int bad_count = 0, n_tests = 0, seed = 41512, cyc = 0;
    assign sda = ~(host_pull | (sda_oe & ~sda_o) | sda_oe_fixed); // released means high
    always #5 clk_i = ~clk_i;
    i2c_register_access_slave #(.FIXED_ADDR_VERSION(0)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .factory_address_select_i(strap),
        .wr_o(wr), .rd_addr_o(rd_addr), .rd_data_i(rf[rd_addr]));
    // fixed-address build on the same bus; it must ignore the other addresses
    i2c_register_access_slave #(.FIXED_ADDR_VERSION(1)) dut_fixed (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_fixed), .factory_address_select_i(strap),
        .wr_o(), .rd_addr_o(), .rd_data_i(8'h00));
    i2c_host_model host (.scl_o(scl), .pull_o(host_pull), .sda_i(sda));
    // ------------------------------------------------------------
    // register file, strobe capture and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wr.en === 1'b1) begin
            wq.push_back({wr.addr, wr.data});
            rf[wr.addr] <= wr.data;
        end
        // whole run needs roughly 80k cycles
        if (cyc == 95000) begin
            bad_count++;
            $display("timeout after %0d cycles", cyc);
            close_out();
        end
    end
    // addresses the port should accept
    function automatic logic valid(input logic [7:0] a);
        return a <= 8'h07 || a == 8'h50 || a == 8'h51;
    endfunction
    // start, own address, register address
    task automatic head(input logic [7:0] ra);
        logic a;
        host.start();
        host.send_byte({own, 1'b0}, a);
        `CHK("addr ack", 1'b1, a)
        host.send_byte(ra, a);
        `CHK("reg ack", valid(ra), a)
    endtask
    // write n random bytes from ra unless ra is invalid, then compare strobes
    task automatic write_seq(input logic [7:0] ra, input int n);
        logic a;
        logic [7:0] b;
        int i;
        eq.delete();
        wq.delete();
        head(ra);
        ptr = ra;
        for (i = 0; i < n && valid(ra); i++) begin
            b = 8'($random(seed));
            host.send_byte(b, a);
            `CHK("data ack", 1'b1, a)
            // an invalid pointer mid-burst is acked but not stored
            if (valid(ptr)) begin
                eq.push_back({ptr, b});
                mdl[ptr] = b;
            end
            if (ptr != 8'h00) ptr++;
        end
        host.stop();
        repeat (10) @(posedge clk_i);
        `CHK("strobe count", eq.size(), wq.size())
        foreach (eq[k]) `CHK("strobe", eq[k], wq[k])
        `CHK("idle", 1'b0, sda_oe)
        `CHK("drive level", 1'b0, sda_o)
    endtask
    // address, repeated start, read n bytes
    task automatic read_seq(input logic [7:0] ra, input int n);
        logic a;
        logic [7:0] b;
        int i;
        head(ra);
        host.start();
        host.send_byte({own, 1'b1}, a);
        `CHK("read addr ack", 1'b1, a)
        ptr = ra;
        for (i = 0; i < n; i++) begin
            host.recv_byte(i < n - 1, b);
            `CHK("read data", mdl[ptr], b)
            ptr++;
        end
        repeat (10) @(posedge clk_i);
        `CHK("released", 1'b0, sda_oe)
        host.stop();
    endtask
    // count line, then the verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic a;
        int k;
        logic [7:0] tbl [7] = '{8'h00, 8'h07, 8'h08, 8'h4f, 8'h50, 8'h51, 8'hff};
        for (k = 0; k < 256; k++) begin
            rf[k] = 8'($random(seed));
            mdl[k] = rf[k];
        end
        repeat (20) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        repeat (10) @(posedge clk_i);
        // foreign address must be ignored
        host.start();
        host.send_byte({7'h29, 1'b0}, a);
        host.stop();
        `CHK("foreign ack", 1'b0, a)
        $display("test foreign address done");
        // edges of the map, 0x00 hold and run past the end
        foreach (tbl[j]) write_seq(tbl[j], 2);
        write_seq(8'h03, 3);
        $display("test writes done");
        read_seq(8'h00, 8);
        read_seq(8'h50, 1);
        $display("test reads done");
        // second reset mid-run with the other strap value
        @(posedge clk_i) #1 arst_n_i = 1'b0;
        strap = 1'b1;
        repeat (20) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        `CHK("reset pointer", 8'h00, rd_addr)
        `CHK("reset release", 1'b0, sda_oe)
        repeat (10) @(posedge clk_i);
        host.start();
        host.send_byte({7'h68, 1'b0}, a);
        host.stop();
        `CHK("old address ack", 1'b0, a)
        own = 7'h6c;
        write_seq(8'h01, 1);
        read_seq(8'h01, 2);
        $display("test strap done");
        // fixed build answers its own address whatever the strap says
        host.start();
        host.send_byte({7'h28, 1'b0}, a);
        `CHK("fixed addr ack", 1'b1, a)
        host.send_byte(8'h08, a);
        `CHK("fixed reg nack", 1'b0, a)
        host.stop();
        $display("test fixed address done");
        close_out();
    end
endmodule
